// ### bench/iwp_master.sv
// serial bus master model that drives the bus clock and pulls the data line
`timescale 1ns/1ps
module iwp_master (
   input  wire logic core_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   localparam int Q = 8; // quarter bit in core cycles, half period 640 ns
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // wait whole core cycles, changes land just after the falling edge
   task automatic w(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start();
      sda_oe_o = 1'b0;
      w(Q);
      scl_o = 1'b1;
      w(2*Q);
      sda_oe_o = 1'b1;
      w(2*Q);
      scl_o = 1'b0;
   endtask
   // send one bit, data set up only while the clock is low
   task automatic bit_w(input logic b);
      w(Q);
      sda_oe_o = !b;
      w(Q);
      scl_o = 1'b1;
      w(2*Q);
      scl_o = 1'b0;
   endtask
   // release the line and sample it in the middle of the high phase
   task automatic bit_r(output logic b);
      sda_oe_o = 1'b0;
      w(2*Q);
      scl_o = 1'b1;
      w(Q);
      b = sda_i;
      w(Q);
      scl_o = 1'b0;
   endtask
   // stop: data rises while the clock is high, bus left idle
   task automatic stop();
      w(Q);
      sda_oe_o = 1'b1;
      w(Q);
      scl_o = 1'b1;
      w(2*Q);
      sda_oe_o = 1'b0;
      w(4*Q);
   endtask
   // send n bits msb first, then read the acknowledge if the byte is whole
   task automatic byte_w(input logic [7:0] d, input int n, output logic ack);
      logic b;
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--) bit_w(d[i]);
      if (n == 8) begin
         bit_r(b);
         ack = !b;
      end
   endtask
   // read one byte and refuse it with a high acknowledge bit
   task automatic byte_r(output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_r(d[i]);
      bit_w(1'b1);
   endtask
endmodule

// ### bench/test_i2c_wiper_register_access.sv
// self-checking bench for the serial wiper position target
`timescale 1ns/1ps
module test_i2c_wiper_register_access;
   localparam logic [6:0] TA = iwp_pkg::TARGET_ADDR_DEF;
   logic         core_clk_i = 1'b0;
   logic         nrst_i = 1'b1;
   logic         scl, m_oe, sda_oe, sda_o;
   logic [6:0]   wpos;
   logic [127:0] taps;
   logic         sda;
   int           err_count = 0;
   int           samples_checked = 0;
   int           exp_pos = 'h40; // model of the position register
   int           cyc = 0;
   logic [31:0]  rnd = 32'h3E8B;
   logic         ack;
   always #20 core_clk_i = ~core_clk_i;
   assign sda = !(m_oe || (sda_oe && !sda_o)); // pulled-up open-drain line
   iwp_target DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .wiper_position_o(wpos), .tap_select_o(taps));
   iwp_master MST (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
   // ---------------------------------------------------------------
   // checking and reporting
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      samples_checked++;
      if (e !== g) begin
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic chk_pos();
      chk("wiper_position", exp_pos[6:0], wpos);
      chk("tap_select", 128'h1 << exp_pos[6:0], taps);
   endtask
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   // ---------------------------------------------------------------
   // transactions
   // ---------------------------------------------------------------
   task automatic wr(input logic [6:0] a, input logic [7:0] r, d, input int n,
                     input logic [2:0] ea);
      logic [2:0] g;
      MST.start();
      MST.byte_w({a, 1'b0}, 8, g[2]);
      MST.byte_w(r, 8, g[1]);
      MST.byte_w(d, n, g[0]);
      if (n == 7) chk("wiper_before_ack", exp_pos[6:0], wpos);
      MST.stop();
      chk("write_acks", ea, g);
      if (ea == 3'b111) exp_pos = int'(d[6:0]);
      chk_pos();
   endtask
   task automatic rd(input logic [6:0] a, input logic [2:0] ea);
      logic [2:0] g;
      logic [7:0] d;
      MST.start();
      MST.byte_w({a, 1'b0}, 8, g[2]);
      MST.byte_w(8'h00, 8, g[1]);
      MST.start();
      MST.byte_w({a, 1'b1}, 8, g[0]);
      if (ea[0]) MST.byte_r(d);
      if (ea[0]) chk("read_data", {1'b0, exp_pos[6:0]}, d);
      chk("sda_released", 1'b0, sda_oe);
      MST.stop();
      chk("read_acks", ea, g);
   endtask
   // cut a hang short
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         final_report();
      end
   end
   // main sequence: boundaries, random data, aborts and refusals
   initial begin
      #1 nrst_i = 1'b0; // a real falling edge so the asynchronous reset acts at once
      repeat (10) @(negedge core_clk_i);
      nrst_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      chk_pos();
      rd(TA, 3'b111);
      wr(TA, 8'h00, 8'hFF, 8, 3'b111);
      wr(TA, 8'h00, 8'h80, 8, 3'b111);
      for (int i = 0; i < 6; i++) begin
         rnd = xs(rnd);
         wr(TA, 8'h00, rnd[7:0], 8, 3'b111);
         rd(TA, 3'b111);
      end
      // second reset in mid-run: the position must return to midscale
      nrst_i = 1'b0;
      repeat (10) @(negedge core_clk_i);
      nrst_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      exp_pos = 'h40;
      chk_pos();
      rd(TA, 3'b111);
      wr(TA, 8'h00, ~rnd[7:0], 7, 3'b110);
      wr(TA ^ 7'h01, 8'h00, 8'h11, 8, 3'b000);
      wr(TA, 8'h01, 8'h22, 8, 3'b100);
      rd(TA ^ 7'h40, 3'b000);
      MST.start();
      MST.byte_w({TA, 1'b1}, 8, ack);
      MST.stop();
      chk("read_without_register_byte", 1'b0, ack);
      final_report();
   end
endmodule

// ### hdl/iwp_pkg.sv
// shared constants for the serial wiper position target
package iwp_pkg;
   // ---------------------------------------------------------------
   // register map and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_WIPER_POSITION = 8'h00;
   localparam logic [6:0] WIPER_RESET        = 7'h40;
   localparam int         WIPER_BITS         = 7;
   localparam int         TAP_COUNT          = 128;
   // arbitrary target address value, not tied to any real part
   localparam logic [6:0] TARGET_ADDR_DEF    = 7'h2A;
   localparam logic [3:0] BIT_COUNT_LAST     = 4'h7;
   localparam logic [1:0] SYNC_RESET         = 2'h3;
endpackage

// ### hdl/iwp_sync.sv
// two flip-flop synchroniser with edge detection of the synchronised level
`timescale 1ns/1ps
module iwp_sync (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic [1:0] sync_q;
   logic       last_q;

   // ---------------------------------------------------------------
   // sampling chain; stage 0 feeds only stage 1
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_q <= iwp_pkg::SYNC_RESET;
         last_q <= 1'b1;
      end else begin
         sync_q <= {sync_q[0], async_i};
         last_q <= sync_q[1];
      end
   end

   // edge decode on the clean copy
   assign level_o = sync_q[1];
   assign rise_o  = sync_q[1] & ~last_q;
   assign fall_o  = ~sync_q[1] & last_q;
endmodule

// ### hdl/iwp_target.sv
// serial bus target holding the volatile wiper position register
`timescale 1ns/1ps
module iwp_target #(
   parameter logic [6:0] TARGET_ADDR = iwp_pkg::TARGET_ADDR_DEF,
   parameter int         TAPS        = iwp_pkg::TAP_COUNT
) (
   input  wire logic            core_clk_i,
   input  wire logic            nrst_i,
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe_o,
   output logic [6:0]           wiper_position_o,
   output logic [TAPS-1:0]      tap_select_o
);
   // ---------------------------------------------------------------
   // reset release and pin sampling
   // ---------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_REG  = 6'h04,
      ST_DATA = 6'h08,
      ST_SEND = 6'h10,
      ST_WAIT = 6'h20
   } iwp_state_type;

   logic [1:0] rst_sync_q;
   logic       rst_n;
   logic       scl_lvl;
   logic       scl_rise;
   logic       scl_fall;
   logic       sda_lvl;
   logic       sda_rise;
   logic       sda_fall;

   // reset is asserted at once and released through two flops
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   iwp_sync u_scl (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .async_i    (scl_i),
      .level_o    (scl_lvl),
      .rise_o     (scl_rise),
      .fall_o     (scl_fall)
   );
   iwp_sync u_sda (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .async_i    (sda_i),
      .level_o    (sda_lvl),
      .rise_o     (sda_rise),
      .fall_o     (sda_fall)
   );

   // ---------------------------------------------------------------
   // bus conditions and byte framing
   // ---------------------------------------------------------------
   iwp_state_type state_q;
   iwp_state_type state_d;
   logic [3:0]    bit_q;
   logic [7:0]    shift_q;
   logic          ack_phase_q;
   logic          ack_drive_q;
   logic          reg_ok_q;
   logic          read_q;
   logic [6:0]    wiper_position_register_q;
   logic          tx_bit_q;
   logic          tx_en_q;

   wire start_seen = sda_fall & scl_lvl;
   wire stop_seen  = sda_rise & scl_lvl;
   wire byte_done  = scl_rise & ~ack_phase_q & (bit_q == iwp_pkg::BIT_COUNT_LAST);
   wire [7:0] rx_byte   = {shift_q[6:0], sda_lvl};
   wire addr_match = (rx_byte[7:1] == TARGET_ADDR);
   wire reg_match  = (rx_byte == iwp_pkg::REG_WIPER_POSITION);
   // acknowledge decision for the byte just finished
   wire ack_addr   = addr_match & (~rx_byte[0] | reg_ok_q);
   wire ack_now    = (state_q == ST_ADDR) ? ack_addr :
                     (state_q == ST_REG)  ? reg_match :
                     (state_q == ST_DATA);
   // read byte: zero MSB, then stored bits
   wire [7:0] read_byte = {1'b0, wiper_position_register_q};
   // the ack slot opens on the eighth falling edge and closes on the ninth,
   // so the line is only ever pulled or let go while the bus clock is low
   wire ack_open   = scl_fall & ack_phase_q & (bit_q == 4'h8);
   wire ack_slot   = ack_phase_q & (bit_q == 4'h9);
   wire ack_end    = scl_fall & ack_slot;
   // index of the next read bit once bit_q bits have been clocked out
   wire [2:0] tx_idx = 3'(4'h7 - bit_q);

   // next state from the byte and acknowledge phases
   always_comb begin
      state_d = state_q;
      if (start_seen) state_d = ST_ADDR;
      else if (stop_seen) state_d = ST_IDLE;
      else if (byte_done & (state_q != ST_SEND) & ~ack_now) state_d = ST_WAIT;
      else if (ack_end) begin
         unique case (state_q)
            ST_ADDR: state_d = read_q ? ST_SEND : ST_REG;
            ST_REG:  state_d = ST_DATA;
            ST_DATA: state_d = ST_WAIT; // one data byte per write
            ST_SEND: state_d = sda_lvl ? ST_WAIT : ST_SEND;
            default: state_d = state_q;
         endcase
      end
   end

   // bit counter, shift register and acknowledge phase
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q     <= ST_IDLE;
         bit_q       <= 4'h0;
         shift_q     <= 8'h00;
         ack_phase_q <= 1'b0;
         ack_drive_q <= 1'b0;
         read_q      <= 1'b0;
      end else begin
         state_q <= state_d;
         if (start_seen | stop_seen) begin
            bit_q       <= 4'h0;
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
         end else if (byte_done) begin
            shift_q     <= rx_byte;
            ack_phase_q <= 1'b1;
            bit_q       <= 4'h8;
            if (state_q == ST_ADDR) read_q <= rx_byte[0];
            ack_drive_q <= (state_q != ST_SEND) & ack_now;
         end else if (scl_rise & ~ack_phase_q) begin
            shift_q <= rx_byte;
            bit_q   <= bit_q + 4'h1;
         end else if (ack_open) begin
            bit_q <= 4'h9; // ninth clock: acknowledge bit on the line
         end else if (ack_end) begin
            ack_phase_q <= 1'b0;
            ack_drive_q <= 1'b0;
            bit_q       <= 4'h0;
         end
      end
   end

   // register address validity, kept across a repeated start
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) reg_ok_q <= 1'b0;
      else if (stop_seen) reg_ok_q <= 1'b0;
      else if (byte_done & (state_q == ST_REG)) reg_ok_q <= reg_match;
   end

   // ---------------------------------------------------------------
   // wiper position register
   // ---------------------------------------------------------------
   // loads only when the data byte's acknowledge clock completes
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) wiper_position_register_q <= iwp_pkg::WIPER_RESET;
      else if (ack_end & (state_q == ST_DATA) & ack_drive_q)
         wiper_position_register_q <= shift_q[6:0];
   end

   // ---------------------------------------------------------------
   // transmit path for the read byte
   // ---------------------------------------------------------------
   // data changes only while the clock is low
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_bit_q <= 1'b1;
         tx_en_q  <= 1'b0;
      end else if (start_seen | stop_seen) begin
         tx_en_q <= 1'b0;
      end else if (ack_end & (state_d == ST_SEND)) begin
         tx_bit_q <= read_byte[7];
         tx_en_q  <= 1'b1;
      end else if (scl_fall & (state_q == ST_SEND) & ~ack_phase_q) begin
         tx_bit_q <= read_byte[tx_idx];
         tx_en_q  <= 1'b1;
      end else if (scl_fall | (state_q != ST_SEND)) begin
         tx_en_q <= 1'b0; // release for the master's acknowledge bit
      end
   end

   // open-drain: drive only lows
   assign sda_oe_o = (ack_drive_q & ack_slot) | (tx_en_q & ~tx_bit_q);
   assign sda_o    = 1'b0;

   // ---------------------------------------------------------------
   // tap decode, code 0 at the low terminal
   // ---------------------------------------------------------------
   assign wiper_position_o = wiper_position_register_q;
   genvar t;
   generate
      for (t = 0; t < TAPS; t++) begin : g_tap
         assign tap_select_o[t] = (wiper_position_register_q == 7'(t));
      end
   endgenerate

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_data_ack;
      ack_end && state_q == ST_DATA && ack_drive_q;
   endsequence

   a_reset_mid: assert property (@(posedge core_clk_i)
      $rose(rst_n) |-> wiper_position_register_q == 7'h40)
      else $error("wiper not at midscale after reset");
   a_one_hot_tap: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      $onehot(tap_select_o))
      else $error("tap select not one-hot");
   a_tap_order: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      tap_select_o[wiper_position_register_q])
      else $error("tap does not follow position");
   a_write_load: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      s_data_ack |=> wiper_position_register_q == $past(shift_q[6:0]))
      else $error("write data not loaded");
   a_only_data: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !(ack_end && state_q == ST_DATA && ack_drive_q)
      |=> $stable(wiper_position_register_q))
      else $error("wiper changed outside data acknowledge");
   a_bad_reg: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      byte_done && state_q == ST_REG && rx_byte != 8'h00 |=> !ack_drive_q)
      else $error("bad register address acknowledged");
   a_addr_miss: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      byte_done && state_q == ST_ADDR && !addr_match |=> !ack_drive_q ##1 state_q == ST_WAIT)
      else $error("foreign address acknowledged");
   a_read_msb: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      ack_end && state_d == ST_SEND && state_q == ST_ADDR |=> sda_oe_o && tx_en_q && !tx_bit_q)
      else $error("read MSB not zero");
   a_nack_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      state_q == ST_WAIT && !ack_phase_q |-> ##1 !tx_en_q)
      else $error("data driven after not-acknowledge");
endmodule
